// ==== rtl/irt_evt_irq.sv ====
// Sticky event status with write-one-to-clear, a mask of the same layout
// and a level interrupt. Assumes strobes come from the same clock.
`timescale 1ns/100ps

module irt_evt_irq
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Event and software access
  input  wire logic [7:0] evt_i,
  input  wire logic       clr_wr_i,
  input  wire logic       mask_wr_i,
  input  wire logic [7:0] wdat_i,
  // State and interrupt
  output logic      [7:0] status_o,
  output logic      [7:0] mask_o,
  output logic            irq_o
);

  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    status_d = status_q;
    mask_d   = mask_q;
    if (clr_wr_i)
      status_d = status_q & ~wdat_i;
    status_d = (status_d | evt_i) & irt_pkg::EVT_IMPL_MASK;
    if (mask_wr_i)
      mask_d = wdat_i & irt_pkg::EVT_IMPL_MASK;
  end

  // Status and mask registers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      status_q <= irt_pkg::EVT_RST;
      mask_q   <= irt_pkg::EVT_RST;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  assign status_o = status_q;
  assign mask_o   = mask_q;
  assign irq_o    = |(status_q & mask_q);

endmodule // irt_evt_irq

// ==== rtl/irt_pkg.sv ====
// Package of the prescaled interval timer: register indices, field
// positions, reset values, prescaler reload counts and bus carrier types.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package irt_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [4:0] IDX_TIMER_COUNT     = 5'h04;
  localparam logic [4:0] IDX_FLAG_STATUS     = 5'h05;
  localparam logic [4:0] IDX_TIMER_COUNT_IRQ = 5'h0C;
  localparam logic [4:0] IDX_EVT_STATUS      = 5'h10;
  localparam logic [4:0] IDX_EVT_MASK        = 5'h11;

  // Index bit positions used by the timer address groups
  localparam int IDX_BIT_GROUP  = 2;  // Set inside 4-7 and C-F
  localparam int IDX_BIT_STATUS = 0;  // Selects flag status on reads
  localparam int IDX_BIT_IRQEN  = 3;  // Interrupt enable on timer access
  localparam int IDX_BIT_HIGH   = 4;  // Set only for the event registers

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         FLAG_BIT       = 7;      // Timer flag in status
  localparam int         EVT_UFL_BIT    = 0;      // Underflow event bit
  localparam logic [7:0] COUNT_RST      = 8'hFF;
  localparam logic [7:0] COUNT_WRAP     = 8'hFF;
  localparam logic [7:0] COUNT_ZERO     = 8'h00;
  localparam logic [7:0] EVT_RST        = 8'h00;
  localparam logic [7:0] EVT_IMPL_MASK  = 8'h01;  // Implemented event bits
  localparam logic [1:0] DIV_SEL_RST    = 2'h0;

  // ==========================================================================
  // Prescaler reload counts (interval minus one) for divide 1/8/64/1024
  // ==========================================================================
  localparam logic [9:0] PRE_RELOAD_1    = 10'h000;
  localparam logic [9:0] PRE_RELOAD_8    = 10'h007;
  localparam logic [9:0] PRE_RELOAD_64   = 10'h03F;
  localparam logic [9:0] PRE_RELOAD_1024 = 10'h3FF;
  localparam logic [9:0] PRE_RST         = 10'h000;

  // ==========================================================================
  // Bus carrier
  // ==========================================================================
  typedef struct packed {
    logic [4:0] idx;
    logic       we;
    logic       lane0;
    logic [7:0] wdat;
  } irt_req_t;

endpackage

// ==== rtl/irt_prescaler.sv ====
// Prescaler of the interval timer: a one-cycle enable pulse every 1, 8,
// 64 or 1024 clocks. Assumes the restart strobe comes from the same clock.
`timescale 1ns/100ps

module irt_prescaler
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       restart_i,
  input  wire logic [1:0] div_sel_i,
  // Enable pulse
  output logic            tick_o
);

  logic [9:0] pre_q;
  logic [9:0] pre_d;
  logic [9:0] reload;

  // Reload count for the selected divisor
  always_comb
  begin
    case (div_sel_i)
      2'h0:    reload = irt_pkg::PRE_RELOAD_1;
      2'h1:    reload = irt_pkg::PRE_RELOAD_8;
      2'h2:    reload = irt_pkg::PRE_RELOAD_64;
      default: reload = irt_pkg::PRE_RELOAD_1024;
    endcase
  end

  // Pulse at zero; a restart forces zero so the pulse comes next cycle
  assign tick_o = (pre_q == 10'h000);

  always_comb
  begin
    if (restart_i)
      pre_d = 10'h000;
    else if (tick_o)
      pre_d = reload;
    else
      pre_d = pre_q - 10'h001;
  end

  // Prescaler count register
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      pre_q <= irt_pkg::PRE_RST;
    else
      pre_q <= pre_d;
  end

endmodule // irt_prescaler

// ==== rtl/irt_timer.sv ====
// Prescaled 8-bit down-counting interval timer with a classic Wishbone
// slave. Assumes a single 50 MHz clock and a synchronous active-low reset.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps

module irt_timer
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq_o
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  irt_pkg::irt_req_t req;

  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        access;

  logic        tmr_wr;
  logic        tmr_rd;
  logic        flag_rd;
  logic        evt_st_rd;
  logic        evt_mk_rd;
  logic        evt_clr_wr;
  logic        evt_mk_wr;

  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic        flag_q;
  logic        flag_d;
  logic        fast_q;
  logic        fast_d;
  logic        irq_en_q;
  logic        irq_en_d;
  logic [1:0]  div_sel_q;
  logic [1:0]  div_sel_d;

  logic        tick;
  logic        step;
  logic        underflow;
  logic [7:0]  evt_set;
  logic [7:0]  evt_status;
  logic [7:0]  evt_mask;
  logic        evt_irq;

  // ==========================================================================
  // Bus request capture
  // ==========================================================================

  // Pack the Wishbone request into the carrier
  always_comb
  begin
    req.idx   = wb_adr_i[6:2];
    req.we    = wb_we_i;
    req.lane0 = wb_sel_i[0];
    req.wdat  = wb_dat_i[7:0];
  end

  // A request is served in the cycle before ack rises
  assign access = wb_cyc_i & wb_stb_i & ~ack_q;

  // ==========================================================================
  // Address decode
  // ==========================================================================

  // Timer groups 4-7 and C-F; event registers above
  always_comb
  begin
    tmr_wr     = 1'b0;
    tmr_rd     = 1'b0;
    flag_rd    = 1'b0;
    evt_st_rd  = 1'b0;
    evt_mk_rd  = 1'b0;
    evt_clr_wr = 1'b0;
    evt_mk_wr  = 1'b0;
    if (!access)
    begin
      tmr_wr = 1'b0;
    end
    else if (req.idx == irt_pkg::IDX_EVT_STATUS)
    begin
      evt_st_rd  = ~req.we;
      evt_clr_wr = req.we & req.lane0;
    end
    else if (req.idx == irt_pkg::IDX_EVT_MASK)
    begin
      evt_mk_rd = ~req.we;
      evt_mk_wr = req.we & req.lane0;
    end
    else if (!req.idx[irt_pkg::IDX_BIT_HIGH] &&
             req.idx[irt_pkg::IDX_BIT_GROUP])
    begin
      if (req.we)
        tmr_wr = req.lane0;
      else if (req.idx[irt_pkg::IDX_BIT_STATUS])
        flag_rd = 1'b1;
      else
        tmr_rd = 1'b1;
    end
  end

  // ==========================================================================
  // Prescaler
  // ==========================================================================

  // Restarted by each timer write so it pulses on the next cycle
  irt_prescaler u_prescaler
  (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .restart_i  (tmr_wr),
    .div_sel_i  (div_sel_q),
    .tick_o     (tick)
  );

  // ==========================================================================
  // Counter
  // ==========================================================================

  // Single-cycle mode steps every clock, else on prescaler pulses only
  assign step      = fast_q | tick;
  assign underflow = step & ~tmr_wr &
                     (count_q == irt_pkg::COUNT_ZERO);

  // Next count, mode and divisor
  always_comb
  begin
    count_d   = count_q;
    fast_d    = fast_q;
    div_sel_d = div_sel_q;
    if (tmr_wr)
    begin
      count_d   = req.wdat;
      div_sel_d = req.idx[1:0];
      fast_d    = 1'b0;
    end
    else
    begin
      if (underflow)
      begin
        count_d = irt_pkg::COUNT_WRAP;
        fast_d  = 1'b1;
      end
      else if (step)
        count_d = count_q - 8'h01;
      if (tmr_rd && !underflow)
        fast_d = 1'b0;
    end
  end

  // A load in the same cycle as an underflow wins: the write restarts
  // the count and suppresses the underflow, so the flag stays clear.
  // Counter, mode and divisor registers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      count_q   <= irt_pkg::COUNT_RST;
      fast_q    <= 1'b0;
      div_sel_q <= irt_pkg::DIV_SEL_RST;
    end
    else
    begin
      count_q   <= count_d;
      fast_q    <= fast_d;
      div_sel_q <= div_sel_d;
    end
  end

  // ==========================================================================
  // Flag and interrupt enable
  // ==========================================================================

  // Underflow in the read cycle keeps the flag set
  always_comb
  begin
    flag_d   = flag_q;
    irq_en_d = irq_en_q;
    if (tmr_wr || tmr_rd)
    begin
      irq_en_d = req.idx[irt_pkg::IDX_BIT_IRQEN];
      flag_d   = 1'b0;
    end
    if (underflow)
      flag_d = 1'b1;
  end

  // The enable is captured on every counter access, read or write, so a
  // read through an enable-off address also silences the timer flag term of the output; a masked event still drives it.
  // Flag and enable registers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      flag_q   <= 1'b0;
      irq_en_q <= 1'b0;
    end
    else
    begin
      flag_q   <= flag_d;
      irq_en_q <= irq_en_d;
    end
  end

  // ==========================================================================
  // Event status, mask and interrupt
  // ==========================================================================

  // Underflow also lands as a sticky event
  always_comb
  begin
    evt_set              = 8'h00;
    evt_set[irt_pkg::EVT_UFL_BIT] = underflow;
  end

  irt_evt_irq u_evt_irq
  (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .evt_i      (evt_set),
    .clr_wr_i   (evt_clr_wr),
    .mask_wr_i  (evt_mk_wr),
    .wdat_i     (req.wdat),
    .status_o   (evt_status),
    .mask_o     (evt_mask),
    .irq_o      (evt_irq)
  );

  // Timer flag gated by captured enable, or a masked event
  assign irq_o = (flag_q & irq_en_q) | evt_irq;

  // ==========================================================================
  // Read data and acknowledge
  // ==========================================================================

  // Read mux; unmapped indices read zero and are still acknowledged
  always_comb
  begin
    rdat_d = rdat_q;
    ack_d  = access;
    if (access)
    begin
      rdat_d = 32'h0000_0000;
      if (tmr_rd)
        rdat_d[7:0] = count_q;
      else if (flag_rd)
        rdat_d[irt_pkg::FLAG_BIT] = flag_q;
      else if (evt_st_rd)
        rdat_d[7:0] = evt_status;
      else if (evt_mk_rd)
        rdat_d[7:0] = evt_mask;
    end
  end

  // Bus response registers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule // irt_timer

// ==== tb/irt_host_model.sv ====
// Host model: classic Wishbone master issuing single accesses.
// Assumes the bench top irt_timer_tb owns the closing report.
`timescale 1ns/100ps

module irt_host_model
(
  // Clock
  input  wire logic        core_clk_i,
  // Wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i
);
  // ====
  // Idle bus at time zero
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0;
  end
  // One access, held until ack is sampled, then released
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge core_clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_dat_o <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (wb_ack_i !== 1'b1 && n < 16);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~a;                 // Released lines show no stale value
    wb_dat_o <= ~{24'h000000, d};
    if (wb_ack_i !== 1'b1)
    begin
      $display("BAD %0t no bus answer", $time);
      irt_timer_tb.failures++;
      irt_timer_tb.wrap_up();
    end
  endtask
endmodule // irt_host_model

// ==== tb/irt_timer_chk.sv ====
// Checker for the interval timer bus answers and interrupt level.
// Sees only the top ports; bound from the bench top file.
`timescale 1ns/100ps

module irt_timer_chk
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // Bus and interrupt
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o
);
  // ====
  // Decode and mask tracking
  logic       req;
  logic [4:0] idx;
  logic       unm;
  logic       msk_d;
  logic       msk_q;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx = wb_adr_i[6:2];
  assign unm = idx[4] ? (idx[3:1] != 3'h0) : ~idx[2];
  // Mask bit follows acked mask writes
  always_comb
  begin
    msk_d = msk_q;
    if (req && wb_we_i && wb_sel_i[0] && idx == irt_pkg::IDX_EVT_MASK)
      msk_d = wb_dat_i[0];
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      msk_q <= 1'b0;
    else
      msk_q <= msk_d;
  end
  // ====
  // Properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_twr;
    req && wb_we_i && wb_sel_i[0] && idx[2] && !idx[4] && !msk_q;
  endsequence
  sequence s_crd;
    req && !wb_we_i && idx[2] && !idx[0] && !idx[4] && !msk_q;
  endsequence
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_prompt: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  chk_dat_high: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_unmapped_zero: assert property (req && !wb_we_i && unm |=>
    wb_dat_o == 32'h0) else $error("unmapped read not zero");
  chk_wr_clears: assert property (s_twr |=> !irq_o)
    else $error("irq after timer write");
  chk_irq_off: assert property (s_twr ##0 !wb_adr_i[5] |=> !irq_o[*4])
    else $error("irq with enable off");
  chk_rd_clears: assert property (s_crd |=>
    !irq_o || wb_dat_o[7:0] == 8'h00) else $error("read kept irq");
endmodule // irt_timer_chk

// ==== tb/irt_timer_tb.sv ====
// Bench top for the interval timer: host model, design and checker.
// Assumes one 50 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps

module irt_timer_tb;
  // ====
  // Signals
  logic        core_clk_i;
  logic        rst_n_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  int          failures;
  int          comparisons;
  int          k;
  int          per [4] = '{1, 8, 64, 1024};
  logic [7:0]  q;
  // Clock
  always #10 core_clk_i = ~core_clk_i;
  // Host and design
  irt_host_model host (.core_clk_i(core_clk_i), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
    .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wb_ack_i(wb_ack_o),
    .wb_dat_i(wb_dat_o));
  irt_timer irt_timer_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cycles until irq rises, bounded
  task automatic wait_irq(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    while (irq_o !== 1'b1 && n < 4096);
    if (irq_o !== 1'b1)
    begin
      $display("BAD %0t no irq", $time);
      failures++;
      wrap_up();
    end
  endtask
  // ====
  // Sequence
  initial
  begin
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    host.acc(1'b0, 8'h44, 8'h00, q);
    chk(q, irt_pkg::EVT_RST);
    host.acc(1'b0, 8'h40, 8'h00, q);
    chk(q, irt_pkg::EVT_RST);
    host.acc(1'b0, 8'h7C, 8'h00, q);
    chk(q, 8'h00);
    // Count 2 at every divisor through indices C-F, irq on
    for (int d = 0; d < 4; d++)
    begin
      host.acc(1'b1, 8'h30 + 8'(4 * d), 8'h02, q);
      wait_irq(k);
      chk(k, 32'(2 * per[d]));
      // Read through index E keeps the enable on, so irq shows the flag
      host.acc(1'b0, 8'h38, 8'h00, q);
      chk(q, 8'hFE);
      chk(irq_o, 1'b0);
      // Back at the prescaled rate, on the phase of the first decrement
      host.acc(1'b0, 8'h38, 8'h00, q);
      chk(q, (d == 0) ? 8'hFB : 8'hFD);
    end
    // Count 2 at divide 1: the read lands on the underflow edge
    host.acc(1'b1, 8'h30, 8'h02, q);
    host.acc(1'b0, 8'h38, 8'h00, q);
    chk(q, 8'h00);
    chk(irq_o, 1'b1);
    host.acc(1'b0, 8'h14, 8'h00, q);
    chk(q, 8'h80);
    // Count 0 at index 4: flag visible, irq stays low
    host.acc(1'b1, 8'h10, 8'h00, q);
    host.acc(1'b0, 8'h14, 8'h00, q);
    chk(q, 8'h80);
    chk(irq_o, 1'b0);
    // Event status, mask and clear
    host.acc(1'b1, 8'h44, 8'h01, q);
    chk(irq_o, 1'b1);
    host.acc(1'b0, 8'h40, 8'h00, q);
    chk(q, 8'h01);
    host.acc(1'b1, 8'h40, 8'h01, q);
    chk(irq_o, 1'b0);
    wait_irq(k);
    chk(k, 244);
    wrap_up();
  end
endmodule // irt_timer_tb

bind irt_timer irt_timer_chk irt_timer_chk_inst (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o));
